// file: design/mfr_cmd_consts.svh
// Command codes, option fields, reset values and timing for the manufacturer commands
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Status history command answers with a block read of exactly thirty-two bytes.
// - Capture starts right after ramp-up, one word every 8 s, sixteen words.
// - Block packs word 0 in bits 15:0, word n in next slot, word 15 on top.
// - Option bit 7 set: every transaction needs a valid packet error check byte.
// - Option bit 6 enables hybrid ratio regulation below the input warning threshold.
// - Option bit 5 selects linear (0) or non-linear (1) droop slope.
// - Option bit 3 enables adaptive ramp time and dynamic loop compensation together.
// - Option bit 2 enables the dynamic bus voltage function.
// - Option bits 1 and 0 are reserved and drive nothing.
// - Temperature offset is a 16-bit word read, one unit per 0.1 degree.
// - Calibration read gives four bytes: offset in bytes 0-1, slope in bytes 2-3.
// - Sensor select bit 0: internal sensor when clear, remote sensor when set.
// ----------------------------------------------------------------------------
`ifndef MFR_CMD_CONSTS_SVH
`define MFR_CMD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define CMD_SENSOR_SELECT 8'hDC
`define CMD_STATUS_HISTORY 8'hDF
`define CMD_SPECIAL_OPTION 8'hE0
`define CMD_TEMP_OFFSET 8'hE1
`define CMD_REMOTE_CAL 8'hE2

// ----------------------------------------------------------------------------
// Answer lengths in bytes
// ----------------------------------------------------------------------------
`define LEN_HISTORY 6'h20
`define LEN_CAL 6'h04
`define LEN_WORD 6'h02
`define LEN_BYTE 6'h01

// ----------------------------------------------------------------------------
// Option byte fields
// ----------------------------------------------------------------------------
`define OPT_PEC_BIT 7
`define OPT_HRR_BIT 6
`define OPT_DROOP_BIT 5
`define OPT_ADAPT_BIT 3
`define OPT_DBV_BIT 2
`define OPT_RESET 8'h00
`define SENSOR_RESET 8'h00
`define SENSOR_EXT_BIT 0

// ----------------------------------------------------------------------------
// Capture timing
// ----------------------------------------------------------------------------
`define HISTORY_WORDS 16
`define STATUS_INTERVAL_S 8
`define CLK_HZ 20000000

`endif

// file: design/mfr_cmd_pkg.sv
// Types shared by the manufacturer command register block
package mfr_cmd_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] wdata;
        logic pec_ok;
    } cmd_req_t;

    typedef struct packed {
        logic valid;
        logic [5:0] len;
        logic [255:0] data;
        logic fault_cmd;
        logic fault_data;
        logic fault_pec;
    } cmd_rsp_t;

    typedef struct packed {
        logic pec_required;
        logic hybrid_ratio_regulation;
        logic droop_slope_select;
        logic adaptive_ramp_dynamic_comp;
        logic dynamic_bus_voltage;
        logic temp_sensor_ext;
    } mode_out_t;

    typedef enum logic [1:0] {
        CAP_WAIT,
        CAP_RUN,
        CAP_DONE
    } cap_state_t;

endpackage : mfr_cmd_pkg

// file: design/mfr_cmd_regs.sv
// Manufacturer command register bank: status history, option byte and temperature data
`timescale 1ns/1ns
`include "mfr_cmd_consts.svh"

module mfr_cmd_regs #(
    parameter int unsigned CAPTURE_INTERVAL = `STATUS_INTERVAL_S * `CLK_HZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Decoded command from the bus front end
    input wire mfr_cmd_pkg::cmd_req_t cmd_req,
    output mfr_cmd_pkg::cmd_rsp_t cmd_rsp,
    // Regulator status and ramp
    input wire logic ramp_done,
    input wire logic [15:0] status_word,
    // Trimmed temperature constants
    input wire logic [15:0] temp_offset_int,
    input wire logic [15:0] remote_cal_offset,
    input wire logic [15:0] remote_cal_slope,
    // Mode controls to the regulation loop
    output mfr_cmd_pkg::mode_out_t mode_out
);
    import mfr_cmd_pkg::*;

    // ------------------------------------------------------------------------
    // Ramp input synchroniser
    // ------------------------------------------------------------------------
    // Two stages before any logic reads the pin; a third flop finds the edge
    logic ramp_meta_q;
    logic ramp_sync_q;
    logic ramp_prev_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ramp_meta_q <= 1'b0;
            ramp_sync_q <= 1'b0;
            ramp_prev_q <= 1'b0;
        end else begin
            ramp_meta_q <= ramp_done;
            ramp_sync_q <= ramp_meta_q;
            ramp_prev_q <= ramp_sync_q;
        end
    end

    // ------------------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------------------
    // Only the first ramp after reset is recorded; later ramps leave history as is.
    cap_state_t cap_state_q, cap_state_d;
    logic [31:0] tick_q, tick_d;
    logic [3:0] index_q, index_d;
    logic [15:0] hist_q [`HISTORY_WORDS];
    logic store;

    // Counter is 32 bits so the full interval at the real clock fits
    localparam logic [31:0] TICK_LAST = 32'(CAPTURE_INTERVAL - 1);

    always_comb begin
        cap_state_d = cap_state_q;
        tick_d = tick_q;
        index_d = index_q;
        store = 1'b0;
        case (cap_state_q)
            CAP_WAIT: begin
                if (ramp_sync_q && !ramp_prev_q) begin
                    store = 1'b1;
                    tick_d = 32'h0;
                    index_d = 4'h1;
                    cap_state_d = CAP_RUN;
                end
            end
            CAP_RUN: begin
                if (tick_q == TICK_LAST) begin
                    store = 1'b1;
                    tick_d = 32'h0;
                    // Wraps after word 15, harmless once capture has stopped
                    index_d = index_q + 4'h1;
                    if (index_q == 4'(`HISTORY_WORDS - 1)) begin
                        cap_state_d = CAP_DONE;
                    end
                end else begin
                    tick_d = tick_q + 32'h1;
                end
            end
            default: begin
                cap_state_d = CAP_DONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cap_state_q <= CAP_WAIT;
            tick_q <= 32'h0;
            index_q <= 4'h0;
        end else begin
            cap_state_q <= cap_state_d;
            tick_q <= tick_d;
            index_q <= index_d;
        end
    end

    // ------------------------------------------------------------------------
    // History storage
    // ------------------------------------------------------------------------
    // Each slot is written once and then keeps its word until reset
    logic [15:0] hist_d [`HISTORY_WORDS];
    logic [255:0] hist_flat;

    for (genvar i = 0; i < `HISTORY_WORDS; i++) begin : g_hist
        always_comb begin
            hist_d[i] = hist_q[i];
            if (store && index_q == 4'(i)) begin
                hist_d[i] = status_word;
            end
        end

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                hist_q[i] <= 16'h0000;
            end else begin
                hist_q[i] <= hist_d[i];
            end
        end

        assign hist_flat[16*i +: 16] = hist_q[i];
    end

    // ------------------------------------------------------------------------
    // Command handling
    // ------------------------------------------------------------------------
    logic [7:0] option_q, option_d;
    logic [7:0] sensor_q, sensor_d;
    cmd_rsp_t rsp_q, rsp_d;
    mode_out_t mode_q, mode_d;

    always_comb begin
        option_d = option_q;
        sensor_d = sensor_q;
        // A refused request still answers, so the host always sees the fault
        rsp_d = '0;
        rsp_d.valid = cmd_req.valid;
        if (!cmd_req.valid) begin
            rsp_d.valid = 1'b0;
        end else if (option_q[`OPT_PEC_BIT] && !cmd_req.pec_ok) begin
            rsp_d.fault_pec = 1'b1;
        end else if (cmd_req.code == `CMD_SPECIAL_OPTION) begin
            if (cmd_req.write) begin
                option_d = cmd_req.wdata;
            end else begin
                rsp_d.len = `LEN_BYTE;
                rsp_d.data = {248'h0, option_q};
            end
        end else if (cmd_req.code == `CMD_SENSOR_SELECT) begin
            if (cmd_req.write) begin
                sensor_d = cmd_req.wdata;
            end else begin
                rsp_d.len = `LEN_BYTE;
                rsp_d.data = {248'h0, sensor_q};
            end
        end else if (cmd_req.code == `CMD_STATUS_HISTORY) begin
            if (cmd_req.write) begin
                rsp_d.fault_data = 1'b1;
            end else begin
                rsp_d.len = `LEN_HISTORY;
                rsp_d.data = hist_flat;
            end
        end else if (cmd_req.code == `CMD_TEMP_OFFSET) begin
            if (cmd_req.write) begin
                rsp_d.fault_data = 1'b1;
            end else begin
                rsp_d.len = `LEN_WORD;
                rsp_d.data = {240'h0, temp_offset_int};
            end
        end else if (cmd_req.code == `CMD_REMOTE_CAL) begin
            if (cmd_req.write) begin
                rsp_d.fault_data = 1'b1;
            end else begin
                rsp_d.len = `LEN_CAL;
                rsp_d.data = {224'h0, remote_cal_slope, remote_cal_offset};
            end
        end else begin
            rsp_d.fault_cmd = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Mode controls
    // ------------------------------------------------------------------------
    // Driven from the next option value so a mode changes with the write answer
    always_comb begin
        mode_d = '0;
        // Reserved option bits 1:0 are stored for readback but steer nothing
        mode_d.pec_required = option_d[`OPT_PEC_BIT];
        mode_d.hybrid_ratio_regulation = option_d[`OPT_HRR_BIT];
        mode_d.droop_slope_select = option_d[`OPT_DROOP_BIT];
        mode_d.adaptive_ramp_dynamic_comp = option_d[`OPT_ADAPT_BIT];
        mode_d.dynamic_bus_voltage = option_d[`OPT_DBV_BIT];
        mode_d.temp_sensor_ext = sensor_d[`SENSOR_EXT_BIT];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            option_q <= `OPT_RESET;
            sensor_q <= `SENSOR_RESET;
            rsp_q <= '0;
            mode_q <= '0;
        end else begin
            option_q <= option_d;
            sensor_q <= sensor_d;
            rsp_q <= rsp_d;
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cmd_rsp = rsp_q;
    assign mode_out = mode_q;

endmodule : mfr_cmd_regs

// file: tb/mfr_cmd_regs_properties.sv
// Assertion checker for the manufacturer command register bank
`timescale 1ns/1ns
`include "mfr_cmd_consts.svh"
module mfr_cmd_regs_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Command port and trims
    input wire mfr_cmd_pkg::cmd_req_t cmd_req,
    input wire mfr_cmd_pkg::cmd_rsp_t cmd_rsp,
    input wire logic [15:0] temp_offset_int,
    input wire logic [15:0] remote_cal_offset,
    input wire logic [15:0] remote_cal_slope,
    input wire mfr_cmd_pkg::mode_out_t mode_out
);
    import mfr_cmd_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic acc;
    // Request that survives the checksum gate
    assign acc = cmd_req.valid && !(mode_out.pec_required && !cmd_req.pec_ok);
    sequence s_rd(logic [7:0] c); acc && !cmd_req.write && cmd_req.code == c; endsequence
    sequence s_wr(logic [7:0] c); acc && cmd_req.write && cmd_req.code == c; endsequence
    property p_hist; s_rd(`CMD_STATUS_HISTORY) |=> cmd_rsp.valid && cmd_rsp.len == `LEN_HISTORY; endproperty
    a_hist: assert property (p_hist) else $error("history length wrong");
    property p_pec; cmd_req.valid && mode_out.pec_required && !cmd_req.pec_ok
        |=> cmd_rsp.fault_pec && cmd_rsp.len == 6'h00; endproperty
    a_pec: assert property (p_pec) else $error("missing checksum accepted");
    property p_hrr; s_wr(`CMD_SPECIAL_OPTION) |=> mode_out.hybrid_ratio_regulation == $past(cmd_req.wdata[6]); endproperty
    a_hrr: assert property (p_hrr) else $error("ratio mode wrong");
    property p_dls; s_wr(`CMD_SPECIAL_OPTION) |=> mode_out.droop_slope_select == $past(cmd_req.wdata[5]); endproperty
    a_dls: assert property (p_dls) else $error("droop select wrong");
    property p_art; s_wr(`CMD_SPECIAL_OPTION) |=> mode_out.adaptive_ramp_dynamic_comp == $past(cmd_req.wdata[3]);
    endproperty
    a_art: assert property (p_art) else $error("adaptive ramp wrong");
    property p_dbv; s_wr(`CMD_SPECIAL_OPTION) |=> mode_out.dynamic_bus_voltage == $past(cmd_req.wdata[2]); endproperty
    a_dbv: assert property (p_dbv) else $error("bus voltage mode wrong");
    property p_toff; s_rd(`CMD_TEMP_OFFSET) |=> cmd_rsp.len == `LEN_WORD
        && cmd_rsp.data[15:0] == $past(temp_offset_int); endproperty
    a_toff: assert property (p_toff) else $error("offset read wrong");
    property p_cal; s_rd(`CMD_REMOTE_CAL) |=> cmd_rsp.len == `LEN_CAL
        && cmd_rsp.data[31:0] == {$past(remote_cal_slope), $past(remote_cal_offset)}; endproperty
    a_cal: assert property (p_cal) else $error("calibration read wrong");
    property p_sens; s_wr(`CMD_SENSOR_SELECT) |=> mode_out.temp_sensor_ext == $past(cmd_req.wdata[0]); endproperty
    a_sens: assert property (p_sens) else $error("sensor select wrong");
    property p_ro; acc && cmd_req.write && (cmd_req.code inside {`CMD_STATUS_HISTORY, `CMD_TEMP_OFFSET,
        `CMD_REMOTE_CAL}) |=> cmd_rsp.fault_data && $stable(mode_out); endproperty
    a_ro: assert property (p_ro) else $error("read-only write accepted");
endmodule : mfr_cmd_regs_properties

bind mfr_cmd_regs mfr_cmd_regs_properties chk_u (.ref_clk(ref_clk), .rstn(rstn), .cmd_req(cmd_req),
    .cmd_rsp(cmd_rsp), .temp_offset_int(temp_offset_int), .remote_cal_offset(remote_cal_offset),
    .remote_cal_slope(remote_cal_slope), .mode_out(mode_out));

// file: tb/host_model.sv
// Host-side command source for the register bank
`timescale 1ns/1ns
`include "mfr_cmd_consts.svh"
module host_model (
    // Orders from the bench
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] code,
    input wire logic [7:0] wdata,
    input wire logic pec_bad,
    // Command to the device
    output mfr_cmd_pkg::cmd_req_t cmd_req
);
    import mfr_cmd_pkg::*;
    // Reserved option bits always sent at their reset value
    always_comb begin
        cmd_req.valid = go;
        cmd_req.write = wr;
        cmd_req.code = code;
        cmd_req.wdata = (code == `CMD_SPECIAL_OPTION) ? {wdata[7:2], 2'h0} : wdata;
        cmd_req.pec_ok = !pec_bad;
    end
endmodule : host_model

// file: tb/tb.sv
// Self-checking bench for the manufacturer command register bank
`timescale 1ns/1ns
`include "mfr_cmd_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    import mfr_cmd_pkg::*;
    localparam int unsigned IVL = 10;
    logic ref_clk = 0, rstn = 0, go = 0, wr = 0, pec_bad = 0, ramp_done = 0;
    logic [7:0] code = 8'h00, wd = 8'h00, d;
    logic [15:0] status_word = 16'h0000, toff = 16'h0000, coff = 16'h0000, cslope = 16'h0000;
    logic [255:0] hexp;
    cmd_req_t cmd_req;
    cmd_rsp_t cmd_rsp, r;
    mode_out_t mode_out;
    int n_errors = 0, checks_done = 0, cyc = 0, rise, w0;
    int hq[$];
    always #25 ref_clk = ~ref_clk;
    host_model host_u (.go(go), .wr(wr), .code(code), .wdata(wd), .pec_bad(pec_bad), .cmd_req(cmd_req));
    mfr_cmd_regs #(.CAPTURE_INTERVAL(IVL)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .cmd_req(cmd_req),
        .cmd_rsp(cmd_rsp), .ramp_done(ramp_done), .status_word(status_word), .temp_offset_int(toff),
        .remote_cal_offset(coff), .remote_cal_slope(cslope), .mode_out(mode_out));
    // Status word doubles as a cycle stamp
    always @(negedge ref_clk) begin
        status_word <= status_word + 16'h0001;
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] x, input logic bad);
        wr = w; code = c; wd = x; pec_bad = bad; go = 1;
        // Answer stands for one cycle only; take it mid-cycle
        @(negedge ref_clk);
        r = cmd_rsp;
        go = 0;
        @(negedge ref_clk);
    endtask : cmd
    task automatic rd(input logic [7:0] c, input logic [5:0] n, input logic [255:0] e);
        cmd(0, c, 8'h00, 0);
        `CHK("valid", 1'b1, r.valid)
        `CHK("len", n, r.len)
        `CHK("data", e, r.data)
        `CHK("faults", 3'h0, {r.fault_cmd, r.fault_data, r.fault_pec})
    endtask : rd
    initial begin
        void'($urandom(31));
        repeat (12) @(negedge ref_clk);
        rstn = 1;
        @(negedge ref_clk);
        rd(`CMD_SPECIAL_OPTION, `LEN_BYTE, 256'h0);
        rd(`CMD_SENSOR_SELECT, `LEN_BYTE, 256'h0);
        ramp_done = 1;
        rise = cyc;
        for (int i = 0; i < 12; i++) begin
            d = 8'($urandom) & 8'h7F;
            cmd(1, `CMD_SPECIAL_OPTION, d, 0);
            `CHK("mode", {d[6:5], d[3:2]}, {mode_out[4:3], mode_out[2:1]})
            rd(`CMD_SPECIAL_OPTION, `LEN_BYTE, {d[7:2], 2'h0});
            d = 8'($urandom);
            cmd(1, `CMD_SENSOR_SELECT, d, 0);
            `CHK("sensor", d[0], mode_out.temp_sensor_ext)
            toff = 16'($urandom);
            coff = 16'($urandom);
            cslope = 16'($urandom);
            rd(`CMD_TEMP_OFFSET, `LEN_WORD, toff);
            rd(`CMD_REMOTE_CAL, `LEN_CAL, {cslope, coff});
        end
        for (int i = 0; i < 3; i++) begin
            cmd(1, i == 0 ? `CMD_STATUS_HISTORY : i == 1 ? `CMD_TEMP_OFFSET : `CMD_REMOTE_CAL, 8'($urandom), 0);
            `CHK("ro", 7'h01, {r.len, r.fault_data})
        end
        cmd(0, 8'hD0, 8'h00, 0);
        `CHK("unknown", 1'b1, r.fault_cmd)
        repeat (200) @(negedge ref_clk);
        cmd(0, `CMD_STATUS_HISTORY, 8'h00, 0);
        w0 = r.data[15:0];
        `CHK("start", 1'b1, w0 > rise && w0 <= rise + 5)
        // Model: word k carries the stamp of word 0 plus k intervals
        for (int k = 0; k < 16; k++) hq.push_back(w0 + k * IVL);
        foreach (hq[k]) hexp[16*k +: 16] = 16'(hq[k]);
        `CHK("hist", hexp, r.data)
        rd(`CMD_STATUS_HISTORY, `LEN_HISTORY, hexp);
        ramp_done = 0;
        repeat (5) @(negedge ref_clk);
        ramp_done = 1;
        repeat (60) @(negedge ref_clk);
        rd(`CMD_STATUS_HISTORY, `LEN_HISTORY, hexp);
        cmd(1, `CMD_SPECIAL_OPTION, 8'h80, 0);
        `CHK("pec on", 1'b1, mode_out.pec_required)
        cmd(0, `CMD_SPECIAL_OPTION, 8'h00, 1);
        `CHK("pec bad", 7'h01, {r.len, r.fault_pec})
        rd(`CMD_SPECIAL_OPTION, `LEN_BYTE, 256'h80);
        cmd(1, `CMD_SPECIAL_OPTION, 8'h00, 0);
        `CHK("pec off", 1'b0, mode_out.pec_required)
        complete_run();
    end
endmodule : tb
